// ===== logic/ccs_core.sv
// Channel command, status and sense logic for the control-unit logical device.
// Assumes the channel offers one command byte at a time, takes bytes with a ready
// handshake and consumes status with an acknowledge.
// What this block does
// [R1] Identify command returns seven identification bytes
// [R2] Alarm command pulses audible alarm, no data
// [R3] Manual-input read sends three filler bytes
// [R4] Position read sends four filler bytes
// [R5] Attention raised on interrupts, with unit check
// [R6] Status modifier, CU end, exception never set
// [R7] Busy after start channel end, during reset
// [R8] Channel end when channel no longer needed
// [R9] Device end when command fully executed
// [R10] Unknown command gives unit check, command reject
// [R11] Bus-out parity error gives unit check, bit 2
// [R12] Internal parity error gives unit check, bit 4
// [R13] Unit check carries channel end, maybe device end
// [R14] Command reject on invalid command or address
// [R15] Sense byte 0 unused bits read zero
// [R16] Sense returns four bytes even when not ready
// [R17] Sense bytes 1-3 from user register
// [R18] Sense error flags cleared after sense
`timescale 1ns/1ps
`default_nettype none
module ccs_core
  import ccs_pkg::*;
#(
  parameter int ALARM_CYCLES = ALARM_CYC,
  parameter int START_CYCLES = START_CYC
) (
  input  wire logic             clk,         // 50 MHz clock
  input  wire logic             rst,         // Sync reset
  input  wire logic             sel_reset,   // Selective reset pulse
  input  wire logic             cmd_valid,   // Command byte offered
  input  wire ccs_pkg::ccs_byte_t cmd_in,    // Command byte, odd parity
  output logic                  cmd_ready,   // Command taken
  input  wire logic             dout_valid,  // Outbound data byte
  input  wire ccs_pkg::ccs_byte_t dout_in,   // Outbound data, odd parity
  output logic                  din_valid,   // Inbound byte valid
  output ccs_pkg::ccs_byte_t    din_out,     // Inbound byte with parity
  input  wire logic             din_ready,   // Channel took byte
  output logic                  stat_valid,  // Status byte presented
  output logic [7:0]            stat_out,    // Status byte
  input  wire logic             stat_ack,    // Channel took status
  input  wire logic             dev_int,     // Real device interrupt
  input  wire logic             app_int,     // Application interrupt
  input  wire logic             int_par_err, // Internal parity error
  input  wire logic             addr_err,    // Illegal address seen
  input  wire logic             not_ready,   // Logical device not ready
  input  wire logic [23:0]      user_sense,  // Sense bytes 1-3
  output logic                  alarm        // Audible alarm drive
);
  initial begin
    if (ALARM_CYCLES < 1 || START_CYCLES < 1) $error("counts must be positive");
  end

  // ==========================================================
  // Command decode and sequencing
  ccs_state_t  st_q;
  logic [2:0]  cnt_q;
  logic [2:0]  len_q;
  logic [7:0]  cmd_q;
  logic [7:0]  stat_q;
  logic [7:0]  sense0_q;
  logic        attn_q;
  logic        cmd_par_ok;
  logic        known;
  logic        start_busy;
  logic        fire_alarm;
  logic        fire_start;
  logic        sense_done;
  logic [7:0]  tx_byte;

  assign cmd_par_ok = ^{cmd_in.data, cmd_in.par};
  assign known = (cmd_in.data == CMD_IDENT) || (cmd_in.data == CMD_ALARM) ||
                 (cmd_in.data == CMD_MANUAL) || (cmd_in.data == CMD_POS) ||
                 (cmd_in.data == CMD_SENSE) || (cmd_in.data == CMD_SETSTRT);
  assign cmd_ready  = (st_q == CCS_IDLE) && !sel_reset;
  assign fire_alarm = cmd_ready && cmd_valid && cmd_par_ok && cmd_in.data == CMD_ALARM; // R2
  assign fire_start = cmd_ready && cmd_valid && cmd_par_ok && cmd_in.data == CMD_SETSTRT;
  assign sense_done = (st_q == CCS_SEND) && (cmd_q == CMD_SENSE) && din_ready &&
                      (cnt_q == len_q - 3'd1);

  ccs_pulse #(.CYCLES(ALARM_CYCLES)) u_alarm (
    .clk  (clk),
    .rst  (rst),
    .fire (fire_alarm),
    .busy (alarm)
  );
  ccs_pulse #(.CYCLES(START_CYCLES)) u_start (
    .clk  (clk),
    .rst  (rst),
    .fire (fire_start),
    .busy (start_busy)
  );

  // Byte chosen by index; filler bytes carry no meaning
  always_comb begin
    tx_byte = FILL_BYTE;
    if (cmd_q == CMD_IDENT) begin
      tx_byte = ID_VALUE[8*(ID_LEN-1-int'(cnt_q)) +: 8]; // R1
    end else if (cmd_q == CMD_SENSE) begin
      if (cnt_q == 3'd0) begin
        tx_byte = sense0_q; // R16
      end else begin
        tx_byte = user_sense[8*(SENSE_LEN-1-int'(cnt_q)) +: 8]; // R17
      end
    end
  end

  // Sequencer; an unknown or bad-parity command ends at once with unit check
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= CCS_IDLE;
      cnt_q  <= 3'd0;
      len_q  <= 3'd0;
      cmd_q  <= 8'h00;
      stat_q <= 8'h00;
    end else if (sel_reset) begin
      st_q   <= CCS_RESET;
      stat_q <= 8'h00;
    end else begin
      case (st_q)
        CCS_RESET: begin
          st_q <= CCS_IDLE;
        end
        CCS_IDLE: begin
          if (cmd_valid) begin
            cmd_q  <= cmd_in.data;
            cnt_q  <= 3'd0;
            stat_q <= 8'h00;
            if (!cmd_par_ok || !known) begin
              stat_q[ST_UC] <= 1'b1; // R10 R11
              stat_q[ST_CE] <= 1'b1; // R13
              stat_q[ST_DE] <= 1'b1; // R13
              st_q <= CCS_STAT;
            end else if (cmd_in.data == CMD_IDENT) begin
              len_q <= 3'(ID_LEN); // R1
              st_q  <= CCS_SEND;
            end else if (cmd_in.data == CMD_MANUAL) begin
              len_q <= 3'(MANUAL_LEN); // R3
              st_q  <= CCS_SEND;
            end else if (cmd_in.data == CMD_POS) begin
              len_q <= 3'(POS_LEN); // R4
              st_q  <= CCS_SEND;
            end else if (cmd_in.data == CMD_SENSE) begin
              len_q <= 3'(SENSE_LEN); // R16
              st_q  <= CCS_SEND;
            end else if (cmd_in.data == CMD_SETSTRT) begin
              stat_q[ST_CE] <= 1'b1; // R8
              st_q <= CCS_HOLD;
            end else begin
              stat_q[ST_CE] <= 1'b1; // R2 R8
              stat_q[ST_DE] <= 1'b1; // R9
              st_q <= CCS_STAT;
            end
          end
        end
        CCS_SEND: begin
          if (din_ready) begin
            if (cnt_q == len_q - 3'd1) begin
              stat_q[ST_CE] <= 1'b1; // R8
              stat_q[ST_DE] <= 1'b1; // R9
              if (cmd_q != CMD_SENSE && (int_par_err || sense0_q != 8'h00)) begin
                stat_q[ST_UC] <= 1'b1; // R12 R13
              end
              st_q <= CCS_STAT;
            end else begin
              cnt_q <= cnt_q + 3'd1;
            end
          end
        end
        CCS_HOLD: begin
          // Channel end goes out now; device end follows when the start work ends
          if (stat_ack) begin
            stat_q <= 8'h00;
          end
          // Device end waits until the channel-end presentation has been taken
          if (!start_busy && (stat_q == 8'h00 || stat_ack)) begin
            stat_q[ST_DE] <= 1'b1; // R9
            st_q <= CCS_STAT;
          end
        end
        CCS_STAT: begin
          if (stat_ack) begin
            stat_q <= 8'h00;
            st_q   <= CCS_IDLE;
          end
        end
        default: begin
          st_q <= CCS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Sense byte 0: set wins over the clear at the end of a sense
  always_ff @(posedge clk) begin
    if (rst) begin
      sense0_q <= 8'h00;
    end else begin
      if (sense_done) begin
        sense0_q <= 8'h00; // R18
      end
      if (cmd_ready && cmd_valid && cmd_par_ok && !known) begin
        sense0_q[SN_CMDREJ] <= 1'b1; // R10 R14
      end
      if (addr_err) begin
        sense0_q[SN_CMDREJ] <= 1'b1; // R14
      end
      if ((cmd_ready && cmd_valid && !cmd_par_ok) ||
          (dout_valid && !(^{dout_in.data, dout_in.par}))) begin
        sense0_q[SN_BUSOUT] <= 1'b1; // R11
      end
      if (int_par_err) begin
        sense0_q[SN_DATCHK] <= 1'b1; // R12
      end
    end
  end

  // Attention from interrupts; set wins over the clear on acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      attn_q <= 1'b0;
    end else begin
      if (stat_ack && st_q == CCS_IDLE) begin
        attn_q <= 1'b0;
      end
      if (dev_int || app_int) begin
        attn_q <= 1'b1; // R5
      end
    end
  end

  // ==========================================================
  // Channel outputs
  assign din_valid    = (st_q == CCS_SEND);
  assign din_out.data = tx_byte;
  assign din_out.par  = ~^tx_byte;

  // Sense is taken while not ready because nothing here gates it on readiness
  logic unused_nr;
  assign unused_nr = not_ready; // R16

  always_comb begin
    stat_out = stat_q;
    if (st_q == CCS_RESET || (st_q == CCS_HOLD && start_busy)) begin
      stat_out[ST_BUSY] = 1'b1; // R7
    end
    if (attn_q && st_q == CCS_IDLE) begin
      stat_out[ST_ATTN] = 1'b1; // R5
      stat_out[ST_UC]   = 1'b1; // R5
    end
    stat_out[ST_MOD] = 1'b0; // R6
    stat_out[ST_CUE] = 1'b0; // R6
    stat_out[ST_UX]  = 1'b0; // R6
  end
  // Busy alone while the start work runs is not a presentation of its own
  assign stat_valid = (stat_out != 8'h00) && !(st_q == CCS_HOLD && stat_q == 8'h00);

  // ==========================================================
  // Checks
  unused_zero_a: assert property (@(posedge clk) disable iff (rst)
    (sense0_q & 8'h57) == 8'h00) else $error("sense byte 0 unused bit set"); // R15
  never_bits_a: assert property (@(posedge clk) disable iff (rst)
    stat_valid |-> !stat_out[ST_MOD] && !stat_out[ST_CUE] && !stat_out[ST_UX])
    else $error("forbidden status bit set"); // R6
  attn_uc_a: assert property (@(posedge clk) disable iff (rst)
    stat_out[ST_ATTN] |-> stat_out[ST_UC]) else $error("attention without unit check"); // R5
  ident_len_a: assert property (@(posedge clk) disable iff (rst || sel_reset)
    (st_q == CCS_IDLE && cmd_valid && cmd_par_ok && cmd_in.data == CMD_IDENT) |=>
    (len_q == 3'd7)) else $error("identify length wrong"); // R1
  manual_len_a: assert property (@(posedge clk) disable iff (rst || sel_reset)
    (st_q == CCS_IDLE && cmd_valid && cmd_par_ok && cmd_in.data == CMD_MANUAL) |=>
    (len_q == 3'd3)) else $error("manual read length wrong"); // R3
  pos_len_a: assert property (@(posedge clk) disable iff (rst || sel_reset)
    (st_q == CCS_IDLE && cmd_valid && cmd_par_ok && cmd_in.data == CMD_POS) |=>
    (len_q == 3'd4)) else $error("position read length wrong"); // R4
  reject_flag_a: assert property (@(posedge clk) disable iff (rst || sel_reset)
    (cmd_ready && cmd_valid && cmd_par_ok && !known) |=>
    sense0_q[SN_CMDREJ] && stat_out[ST_UC] && stat_out[ST_CE])
    else $error("reject not reported"); // R10
  busout_flag_a: assert property (@(posedge clk) disable iff (rst || sel_reset)
    (cmd_ready && cmd_valid && !cmd_par_ok) |=> sense0_q[SN_BUSOUT] && stat_out[ST_UC])
    else $error("bus-out check not reported"); // R11
  datchk_flag_a: assert property (@(posedge clk) disable iff (rst)
    int_par_err |=> sense0_q[SN_DATCHK]) else $error("data check not set"); // R12
  alarm_fire_a: assert property (@(posedge clk) disable iff (rst)
    fire_alarm |=> alarm) else $error("alarm did not sound"); // R2
  reset_busy_a: assert property (@(posedge clk) disable iff (rst)
    sel_reset |=> stat_out[ST_BUSY]) else $error("busy missing in reset"); // R7
  sense_clear_a: assert property (@(posedge clk) disable iff (rst)
    (sense_done && !int_par_err && !addr_err && !dout_valid && !cmd_valid) |=>
    sense0_q == 8'h00) else $error("sense flags not cleared"); // R18
  end_bits_a: assert property (@(posedge clk) disable iff (rst || sel_reset)
    (st_q == CCS_SEND && din_ready && cnt_q == len_q - 3'd1) |=>
    stat_out[ST_CE] && stat_out[ST_DE]) else $error("ending status missing"); // R8 R9 R13
endmodule : ccs_core
`default_nettype wire

// ===== logic/ccs_pkg.sv
// Package for the channel command, status and sense block.
// Assumes one 50 MHz clock; bit 0 of a status or sense byte is its MSB, as on the channel.
package ccs_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_SENSE   = 8'h04;
  localparam logic [7:0] CMD_IDENT   = 8'hE4;
  localparam logic [7:0] CMD_ALARM   = 8'h0B;
  localparam logic [7:0] CMD_MANUAL  = 8'h0E;
  localparam logic [7:0] CMD_POS     = 8'h12;
  localparam logic [7:0] CMD_SETSTRT = 8'h27;
  // ==========================================================
  // Byte counts
  localparam int ID_LEN     = 7;
  localparam int MANUAL_LEN = 3;
  localparam int POS_LEN    = 4;
  localparam int SENSE_LEN  = 4;
  // Identification bytes: arbitrary neutral value
  localparam logic [55:0] ID_VALUE = 56'hA1A2A3A4A5A6A7;
  localparam logic [7:0]  FILL_BYTE = 8'h00;
  // ==========================================================
  // Status byte positions (channel bit n is vector bit 7-n)
  localparam int ST_ATTN = 7;
  localparam int ST_MOD  = 6;
  localparam int ST_CUE  = 5;
  localparam int ST_BUSY = 4;
  localparam int ST_CE   = 3;
  localparam int ST_DE   = 2;
  localparam int ST_UC   = 1;
  localparam int ST_UX   = 0;
  // Sense byte 0 positions
  localparam int SN_CMDREJ = 7;
  localparam int SN_BUSOUT = 5;
  localparam int SN_DATCHK = 3;
  // ==========================================================
  // Timing
  localparam int CLK_HZ      = 50_000_000;
  localparam int ALARM_MS    = 100;
  localparam int ALARM_CYC   = CLK_HZ / 1000 * ALARM_MS;
  localparam int START_US    = 10;
  localparam int START_CYC   = (CLK_HZ / 1_000_000) * START_US;
  // ==========================================================
  typedef enum logic [2:0] {
    CCS_IDLE  = 3'b000,
    CCS_SEND  = 3'b001,
    CCS_STAT  = 3'b010,
    CCS_HOLD  = 3'b011,
    CCS_RESET = 3'b100
  } ccs_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic       par;
  } ccs_byte_t;
endpackage : ccs_pkg

// ===== logic/ccs_pulse.sv
// One-shot counter: holds its output high for a set number of cycles.
// Assumes a single synchronous clock.
`timescale 1ns/1ps
`default_nettype none
module ccs_pulse #(
  parameter int CYCLES = 16
) (
  input  wire logic clk,   // Clock
  input  wire logic rst,   // Sync reset
  input  wire logic fire,  // Start pulse
  output logic      busy   // High while counting
);
  localparam int W = $clog2(CYCLES + 1);
  initial begin
    if (CYCLES < 1) $error("CYCLES must be at least 1");
  end
  logic [W-1:0] cnt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (fire) begin
      cnt_q <= W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign busy = (cnt_q != '0);
endmodule : ccs_pulse
`default_nettype wire

// ===== test/ccs_chan_model.sv
// Host channel model: takes inbound bytes and status, logging each one.
// Assumes the block holds din_valid and stat_valid until its answer is sampled.
`timescale 1ns/1ps
`default_nettype none
module ccs_chan_model
  import ccs_pkg::*;
(
  input  wire logic               clk,        // Clock
  input  wire logic               din_valid,  // Inbound byte offered
  input  wire ccs_pkg::ccs_byte_t din_out,    // Inbound byte
  output logic                    din_ready,  // Byte taken
  input  wire logic               stat_valid, // Status offered
  input  wire logic [7:0]         stat_out,   // Status byte
  output logic                    stat_ack,   // Status taken
  input  wire logic [3:0]         lag         // Cycles to stall before answering
);
  import ccs_pkg::*;
  ccs_byte_t  bytes[$];
  logic [7:0] stats[$];
  int         dw;
  int         sw;
  initial begin
    din_ready = 1'b0;
    stat_ack  = 1'b0;
    dw        = 0;
    sw        = 0;
  end
  // A slow channel stalls each transfer by lag cycles before answering
  always begin
    @(posedge clk);
    if (din_ready && din_valid) bytes.push_back(din_out);
    if (stat_ack && stat_valid) stats.push_back(stat_out);
    #1;
    if (din_ready) din_ready = 1'b0;
    else if (din_valid && dw >= lag) begin
      din_ready = 1'b1;
      dw        = 0;
    end else if (din_valid) dw++;
    if (stat_ack) stat_ack = 1'b0;
    else if (stat_valid && sw >= lag) begin
      stat_ack = 1'b1;
      sw       = 0;
    end else if (stat_valid) sw++;
  end
endmodule : ccs_chan_model
`default_nettype wire

// ===== test/channel_command_status_sense_bench.sv
// Self-checking bench for the command, status and sense block.
// Assumes the channel model answers; alarm and start counts are shortened.
`timescale 1ns/1ps
`default_nettype none
module channel_command_status_sense_bench;
  import ccs_pkg::*;
  localparam int ALM = 8;
  logic clk = 1'b0, rst = 1'b1, sel_reset = 1'b0, cmd_valid = 1'b0, cmd_ready;
  logic din_valid, din_ready, stat_valid, stat_ack, alarm;
  logic dev_int = 1'b0, app_int = 1'b0, int_par_err = 1'b0, addr_err = 1'b0;
  logic not_ready = 1'b1;
  logic [7:0] stat_out;
  logic [3:0] lag = 4'h0;
  logic [23:0] user_sense = 24'h5A3CC3;
  ccs_byte_t cmd_in = '0, din_out;
  logic dout_valid = 1'b0;
  ccs_byte_t dout_in = '{data: 8'h00, par: 1'b1};
  int fail_count = 0, n_tests = 0, cyc = 0;
  always #10 clk = ~clk;
  ccs_core #(.ALARM_CYCLES(ALM), .START_CYCLES(4)) dut (.clk(clk), .rst(rst),
    .sel_reset(sel_reset), .cmd_valid(cmd_valid), .cmd_in(cmd_in), .cmd_ready(cmd_ready),
    .dout_valid(dout_valid), .dout_in(dout_in), .din_valid(din_valid), .din_out(din_out),
    .din_ready(din_ready), .stat_valid(stat_valid), .stat_out(stat_out),
    .stat_ack(stat_ack), .dev_int(dev_int), .app_int(app_int), .int_par_err(int_par_err),
    .addr_err(addr_err), .not_ready(not_ready), .user_sense(user_sense), .alarm(alarm));
  ccs_chan_model chan (.clk(clk), .din_valid(din_valid), .din_out(din_out),
    .din_ready(din_ready), .stat_valid(stat_valid), .stat_out(stat_out),
    .stat_ack(stat_ack), .lag(lag));
  // ==========================================================
  // Checking and closing
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Ceiling is well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  // ==========================================================
  // Channel operations
  task automatic wait_stat(int nst);
    while (chan.stats.size() < nst) @(posedge clk);
    #1;
  endtask : wait_stat
  // Offers one command; bad flips the parity bit to even
  task automatic run(logic [7:0] code, logic bad, int nst);
    chan.bytes.delete();
    chan.stats.delete();
    cmd_in    = '{data: code, par: (~^code) ^ bad};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    cmd_valid = 1'b0;
    wait_stat(nst);
    // Unused status bits must never appear in any presentation
    for (int i = 0; i < nst; i++) chk("unused status", 8'h00, chan.stats[i] & 8'h61);
  endtask : run
  // Sends a byte-returning command and compares length, each byte and its parity
  task automatic data_cmd(string nm, logic [7:0] code, logic [7:0] exp[$]);
    run(code, 1'b0, 1);
    chk({nm, " count"}, 8'(exp.size()), 8'(chan.bytes.size()));
    foreach (exp[i]) begin
      chk({nm, " byte"}, exp[i], chan.bytes[i].data);
      chk({nm, " parity"}, 8'h01, 8'(^chan.bytes[i]));
    end
    chk({nm, " end status"}, 8'h0C, chan.stats[0] & 8'h0C);
  endtask : data_cmd
  task automatic sense(logic [7:0] b0);
    data_cmd("sense", CMD_SENSE, '{b0, user_sense[23:16], user_sense[15:8], user_sense[7:0]});
  endtask : sense
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk) #1;
    s = 1'b0;
    @(posedge clk) #1;
  endtask : pulse
  // ==========================================================
  // Scenarios
  task automatic t_fixed;
    logic [7:0] id[$];
    for (int i = 0; i < ID_LEN; i++) id.push_back(ID_VALUE[55 - 8 * i -: 8]);
    lag = 4'h3;
    data_cmd("ident", CMD_IDENT, id);
    lag = 4'h0;
    data_cmd("manual", CMD_MANUAL, '{8'h00, 8'h00, 8'h00});
    data_cmd("position", CMD_POS, '{8'h00, 8'h00, 8'h00, 8'h00});
    $display("Test fixed replies done");
  endtask : t_fixed
  task automatic t_alarm;
    run(CMD_ALARM, 1'b0, 1);
    chk("alarm status", 8'h0C, chan.stats[0]);
    chk("alarm bytes", 8'h00, 8'(chan.bytes.size()));
    chk("alarm on", 8'h01, {7'h00, alarm});
    repeat (ALM + 2) @(posedge clk);
    #1;
    chk("alarm off", 8'h00, {7'h00, alarm});
    $display("Test alarm done");
  endtask : t_alarm
  task automatic t_errors;
    run(8'h55, 1'b0, 1);
    chk("reject status", 8'h0E, chan.stats[0]);
    sense(8'h80);
    sense(8'h00);
    run(CMD_IDENT, 1'b1, 1);
    chk("parity status", 8'h0E, chan.stats[0]);
    sense(8'h20);
    pulse(int_par_err);
    data_cmd("manual after error", CMD_MANUAL, '{8'h00, 8'h00, 8'h00});
    chk("data check status", 8'h0E, chan.stats[0]);
    sense(8'h08);
    pulse(addr_err);
    sense(8'h80);
    dout_in.par = 1'b0;
    pulse(dout_valid);
    dout_in.par = 1'b1;
    sense(8'h20);
    $display("Test errors done");
  endtask : t_errors
  task automatic t_attn;
    chan.stats.delete();
    pulse(dev_int);
    wait_stat(1);
    chk("device attention", 8'h82, chan.stats[0] & 8'h82);
    chan.stats.delete();
    pulse(app_int);
    wait_stat(1);
    chk("app attention", 8'h82, chan.stats[0] & 8'h82);
    $display("Test attention done");
  endtask : t_attn
  task automatic t_busy;
    run(CMD_SETSTRT, 1'b0, 2);
    chk("start first", 8'h18, chan.stats[0]);
    chk("start second", 8'h04, chan.stats[1]);
    sel_reset = 1'b1;
    @(posedge clk) #1;
    sel_reset = 1'b0;
    // Busy stands only in the single cycle that follows the reset request
    chk("reset busy", 8'h10, stat_out & 8'h10);
    @(posedge clk) #1;
    repeat (4) @(posedge clk);
    #1;
    $display("Test busy done");
  endtask : t_busy
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_fixed();
    t_alarm();
    t_errors();
    t_attn();
    t_busy();
    conclude();
  end
endmodule : channel_command_status_sense_bench
`default_nettype wire
